// [hdl/fce_cascade.sv]
// Depth-expanded chain of fall-through FIFO stages carrying a width-expanded word.
`timescale 1ns/100ps
module fce_cascade #(
	parameter int N_STAGES    = fce_pkg::STAGES,
	parameter int STAGE_DEPTH = fce_pkg::STAGE_DEPTH
) (
	input  wire logic                                       clk_in,
	input  wire logic                                       reset_n_in,
	input  fce_pkg::fce_xfer_t                              write_in,
	output logic                                            input_ready_n_out,
	input  wire logic                                       read_en_in,
	output fce_pkg::fce_word_t                              read_data_out,
	output logic                                            output_ready_n_out,
	output logic [$clog2(N_STAGES*STAGE_DEPTH+1)-1:0]       fill_level_out
);
	import fce_pkg::*;

	localparam int TOTAL = N_STAGES * STAGE_DEPTH; // R8
	localparam int LW    = $clog2(TOTAL + 1);

	// All top-level state: reset synchroniser and chain occupancy.
	typedef struct packed {
		logic [1:0]    rst_sync;
		logic [LW-1:0] level;
	} fce_top_state_t;

	fce_top_state_t state;
	fce_top_state_t next_state;
	logic           rst_n;
	fce_word_t      stage_data [N_STAGES];
	logic           stage_or_n [N_STAGES];
	logic           stage_ir_n [N_STAGES];
	logic           stage_rd   [N_STAGES];
	fce_xfer_t      tail_xfer;
	fce_xfer_t      out_xfer;
	logic           buf_ready;
	logic           accept_wr;
	logic           accept_rd;

	assign rst_n = state.rst_sync[1];

	// Each link moves a word on the edge where the upstream has one and the downstream has room.
	generate
		for (genvar i = 0; i < N_STAGES; i++)
		begin : g_stage
			localparam int DEPTH_I = (i == N_STAGES - 1) ? STAGE_DEPTH - OUT_BUFFER_ENTRIES : STAGE_DEPTH;
			logic      wr_en;
			fce_word_t wr_data;

			if (i == 0)
			begin : g_head
				assign wr_en   = write_in.valid;
				assign wr_data = write_in.data;
			end
			else
			begin : g_link
				assign wr_en   = !stage_or_n[i-1]; // R10
				assign wr_data = stage_data[i-1]; // R7
			end

			if (i == N_STAGES - 1)
			begin : g_last
				assign stage_rd[i] = buf_ready;
			end
			else
			begin : g_mid
				assign stage_rd[i] = !stage_ir_n[i+1]; // R18
			end

			fce_stage #(
				.DEPTH (DEPTH_I),
				.RD_LAT(fce_read_lat(i, N_STAGES)), // R11
				.WR_LAT(fce_write_lat(i, N_STAGES)) // R15
			) u_stage (
				.clk_in            (clk_in),
				.rst_n_in          (rst_n),
				.write_en_in       (wr_en),
				.write_data_in     (wr_data),
				.input_ready_n_out (stage_ir_n[i]),
				.read_en_in        (stage_rd[i]),
				.read_data_out     (stage_data[i]),
				.output_ready_n_out(stage_or_n[i])
			);
		end
	endgenerate

	// The last stage drains into the buffer; its two entries count toward the chain depth.
	assign tail_xfer.valid = !stage_or_n[N_STAGES-1]; // R9
	assign tail_xfer.data  = stage_data[N_STAGES-1];

	fce_skid u_skid (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n),
		.in_xfer_in  (tail_xfer),
		.in_ready_out(buf_ready),
		.out_xfer_out(out_xfer),
		.out_ready_in(read_en_in)
	);

	// A single clock serves write, read and transfer, so paralleled lanes never drift apart.
	assign input_ready_n_out  = stage_ir_n[0]; // R14
	assign output_ready_n_out = !out_xfer.valid; // R10
	assign read_data_out      = out_xfer.data; // R5
	assign accept_wr          = write_in.valid && !stage_ir_n[0];
	assign accept_rd          = read_en_in && out_xfer.valid; // R2
	assign fill_level_out     = state.level;

	// Occupancy follows accepted writes and reads at the chain's ends.
	always_comb
	begin
		next_state          = state;
		next_state.rst_sync = {state.rst_sync[0], 1'b1};
		next_state.level    = LW'(state.level + LW'(accept_wr) - LW'(accept_rd));
		if (!rst_n)
			next_state.level = '0;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			state <= '0;
		else
			state <= next_state;
	end

endmodule : fce_cascade

// [hdl/fce_pkg.sv]
// Shared constants, types and latency helpers for the cascaded first-word-fall-through FIFO chain.
// Operation
// R1: Width-expanded devices share every control; take flags from one except empty/full/ready.
// R2: Paralleled devices may release empty/full or assert ready flags one cycle apart.
// R3: Legacy mode composite empty and full flags are ANDs of each device's flag.
// R4: Fall-through composite output-ready and input-ready flags are ORs of each device's flag.
// R5: Two paralleled devices concatenate data: 18-bit ports give 36, 9-bit give 18.
// R6: Width-expanded devices have equal depth; word widths may differ.
// R7: Depth expansion only in fall-through mode; stage outputs feed next inputs directly.
// R8: Chain depth equals the sum of the stage depths.
// R9: First word into an empty chain falls through to the end without reads.
// R10: A stage with a word at its outputs drives output-ready low, enabling next write.
// R11: Last output-ready falls (N-1)*4 transfer plus 3 read periods after first write.
// R12: Surrounding system allows extra ripple cycles when clock skew limits are missed.
// R13: Ripple latency hits only the first word into an empty chain.
// R14: A stage gaining a free slot drives input-ready low; vacancy moves toward first.
// R15: First input-ready falls (N-1)*3 transfer plus 2 write periods after last read.
// R16: Surrounding system allows extra bubble cycles when clock skew limits are missed.
// R17: Transfer clock is tied to the faster of write and read clocks.
// R18: Each link reads upstream and writes downstream on one edge, gated by both flags.
package fce_pkg;

	// Word layout: two 18-bit lanes side by side.
	localparam int LANE_WIDTH = 18;
	localparam int LANES      = 2;
	localparam int WORD_WIDTH = LANE_WIDTH * LANES;

	// Default chain shape.
	localparam int STAGES      = 2;
	localparam int STAGE_DEPTH = 512;

	// Entries of the output buffer; they are taken out of the last stage's memory.
	localparam int OUT_BUFFER_ENTRIES = 2;

	// Clock period in ns; all ports and links share this one clock.
	localparam int CLK_PERIOD_NS = 8;

	// Latencies in clock periods, and the bit width of the wait timers.
	localparam int READ_FALL_PERIODS  = 3;
	localparam int XFER_RIPPLE_PERIODS = 4;
	localparam int WRITE_FREE_PERIODS = 2;
	localparam int XFER_BUBBLE_PERIODS = 3;
	localparam int LAT_WIDTH          = 4;

	typedef logic [WORD_WIDTH-1:0] fce_word_t;

	// A word together with its qualifier.
	typedef struct packed {
		logic      valid;
		fce_word_t data;
	} fce_xfer_t;

	// Fall-through wait of one stage; only the last stage answers on the read side.
	// Each hop spends one period on the link or buffer edge itself, so the timer runs one short.
	function automatic logic [LAT_WIDTH-1:0] fce_read_lat(input int idx, input int n);
		int lat;
		lat = (idx == n - 1) ? READ_FALL_PERIODS : XFER_RIPPLE_PERIODS;
		return LAT_WIDTH'(lat - 1);
	endfunction : fce_read_lat

	// Free-slot wait of one stage; only the first stage answers on the write side.
	// The hop edge that frees the slot counts as one period, so the timer runs one short.
	function automatic logic [LAT_WIDTH-1:0] fce_write_lat(input int idx, input int n);
		int lat;
		lat = (idx == 0) ? WRITE_FREE_PERIODS : XFER_BUBBLE_PERIODS;
		return LAT_WIDTH'(lat - 1);
	endfunction : fce_write_lat

endpackage : fce_pkg

// [hdl/fce_stage.sv]
// One first-word-fall-through FIFO stage with timed output-ready and input-ready flags.
`timescale 1ns/100ps
module fce_stage #(
	parameter int                          DEPTH  = fce_pkg::STAGE_DEPTH,
	parameter logic [fce_pkg::LAT_WIDTH-1:0] RD_LAT = 4'h3,
	parameter logic [fce_pkg::LAT_WIDTH-1:0] WR_LAT = 4'h2
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       write_en_in,
	input  fce_pkg::fce_word_t write_data_in,
	output logic            input_ready_n_out,
	input  wire logic       read_en_in,
	output fce_pkg::fce_word_t read_data_out,
	output logic            output_ready_n_out
);
	import fce_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [AW-1:0]        wr_ptr;
		logic [AW-1:0]        rd_ptr;
		logic [CW-1:0]        count;
		logic [LAT_WIDTH-1:0] or_wait;
		logic [LAT_WIDTH-1:0] ir_wait;
	} fce_stage_state_t;

	fce_stage_state_t state;
	fce_stage_state_t next_state;
	fce_word_t        mem [DEPTH];
	logic             wr;
	logic             rd;

	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_step

	// Flags fall only once their wait has run out, so a first word is seen late but later ones at once.
	assign output_ready_n_out = !(state.count != '0 && state.or_wait == '0); // R10
	assign input_ready_n_out  = !(state.count != CW'(DEPTH) && state.ir_wait == '0); // R14
	assign wr                 = write_en_in && !input_ready_n_out;
	assign rd                 = read_en_in && !output_ready_n_out;
	assign read_data_out      = mem[state.rd_ptr];

	// Pointer, level and flag-wait bookkeeping.
	always_comb
	begin
		next_state = state;
		if (wr)
			next_state.wr_ptr = ptr_step(state.wr_ptr);
		if (rd)
			next_state.rd_ptr = ptr_step(state.rd_ptr);
		next_state.count = CW'(state.count + CW'(wr) - CW'(rd));
		if (wr && state.count == '0)
			next_state.or_wait = RD_LAT; // R13
		else if (state.or_wait != '0)
			next_state.or_wait = state.or_wait - 1'b1;
		if (rd && state.count == CW'(DEPTH))
			next_state.ir_wait = WR_LAT; // R15
		else if (state.ir_wait != '0)
			next_state.ir_wait = state.ir_wait - 1'b1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state <= '0;
		else
			state <= next_state;
	end

	// Storage needs no reset; the pointers guard every read.
	always_ff @(posedge clk_in)
	begin
		if (wr)
			mem[state.wr_ptr] <= write_data_in;
	end

endmodule : fce_stage

// [hdl/fce_skid.sv]
// Two-entry output buffer so a stall by the reader never drops a word.
`timescale 1ns/100ps
module fce_skid (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  fce_pkg::fce_xfer_t in_xfer_in,
	output logic            in_ready_out,
	output fce_pkg::fce_xfer_t out_xfer_out,
	input  wire logic       out_ready_in
);
	import fce_pkg::*;

	typedef struct packed {
		logic [1:0] count;
		fce_word_t  head;
		fce_word_t  tail;
	} fce_skid_state_t;

	fce_skid_state_t state;
	fce_skid_state_t next_state;
	logic            push;
	logic            pop;

	assign in_ready_out       = state.count != 2'(OUT_BUFFER_ENTRIES);
	assign out_xfer_out.valid = state.count != 2'h0;
	assign out_xfer_out.data  = state.head;
	assign push               = in_xfer_in.valid && in_ready_out;
	assign pop                = out_xfer_out.valid && out_ready_in;

	// Head always holds the oldest word; the tail only fills while the reader stalls.
	always_comb
	begin
		next_state = state;
		if (pop)
			next_state.head = state.tail;
		if (push)
		begin
			if (state.count == 2'h0 || (pop && state.count == 2'h1))
				next_state.head = in_xfer_in.data;
			else
				next_state.tail = in_xfer_in.data;
		end
		next_state.count = 2'(state.count + 2'(push) - 2'(pop));
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state <= '0;
		else
			state <= next_state;
	end

endmodule : fce_skid

// [verif/fce_cascade_sva.sv]
// Port assertions for the cascaded fall-through FIFO chain.
`timescale 1ns/100ps
module fce_cascade_sva #(
	parameter int N_STAGES    = 2,
	parameter int STAGE_DEPTH = 4
) (
	input  wire logic                                       clk_in,
	input  wire logic                                       reset_n_in,
	input  fce_pkg::fce_xfer_t                              write_in,
	input  wire logic                                       input_ready_n_out,
	input  wire logic                                       read_en_in,
	input  fce_pkg::fce_word_t                              read_data_out,
	input  wire logic                                       output_ready_n_out,
	input  wire logic [$clog2(N_STAGES*STAGE_DEPTH+1)-1:0]  fill_level_out
);
	import fce_pkg::*;
	localparam int CAP = N_STAGES * STAGE_DEPTH;
	localparam int RIP = (N_STAGES - 1) * 4 + 3;
	localparam int BUB = (N_STAGES - 1) * 3 + 2;
	logic wr_ok;
	logic rd_ok;
	// A transfer counts only when the chain's own flag allowed it at that edge.
	assign wr_ok = write_in.valid && !input_ready_n_out;
	assign rd_ok = read_en_in && !output_ready_n_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_fill_bound: assert property (fill_level_out <= CAP) else $error("fill level above capacity");
	a_full_refuse: assert property (fill_level_out == CAP |-> input_ready_n_out) else $error("full chain ready");
	a_fill_grow: assert property (wr_ok && !rd_ok |=> fill_level_out == $past(fill_level_out) + 1'b1)
		else $error("write not counted");
	a_fill_shrink: assert property (rd_ok && !wr_ok |=> fill_level_out == $past(fill_level_out) - 1'b1)
		else $error("read not counted");
	a_empty_flag: assert property (fill_level_out == 0 |-> output_ready_n_out) else $error("empty chain shows word");
	a_head_hold: assert property (!output_ready_n_out && !read_en_in |=> !output_ready_n_out && $stable(read_data_out))
		else $error("head word lost without read");
	a_ripple_time: assert property (fill_level_out == 0 && wr_ok |-> ##[RIP:RIP] output_ready_n_out ##1 !output_ready_n_out)
		else $error("first word fall-through time wrong");
	a_bubble_time: assert property (fill_level_out == CAP && rd_ok |-> ##[BUB:BUB] input_ready_n_out ##1 !input_ready_n_out)
		else $error("free slot bubble time wrong");
	c_ripple: cover property (fill_level_out == 0 && wr_ok);
	c_full: cover property (fill_level_out == CAP);
	c_bubble: cover property (fill_level_out == CAP && rd_ok);
endmodule : fce_cascade_sva

bind fce_cascade fce_cascade_sva #(.N_STAGES(N_STAGES), .STAGE_DEPTH(STAGE_DEPTH)) u_sva (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .write_in(write_in), .input_ready_n_out(input_ready_n_out), .read_en_in(read_en_in),
	.read_data_out(read_data_out), .output_ready_n_out(output_ready_n_out), .fill_level_out(fill_level_out));

// [verif/fce_reader.sv]
// Downstream reader model that drains the chain and keeps every word it takes.
`timescale 1ns/100ps
module fce_reader (
	input  wire logic         clk_in,
	input  wire logic         stall_in,
	input  wire logic         output_ready_n_in,
	input  fce_pkg::fce_word_t read_data_in,
	output logic              read_en_out
);
	import fce_pkg::*;
	fce_word_t got[$];
	logic      take = 1'b0;
	fce_word_t held;
	initial read_en_out = 1'b0;
	// Flag and word are looked at half a period early, so the taking edge never sees its own update.
	always @(negedge clk_in)
	begin
		take = read_en_out && !output_ready_n_in;
		held = read_data_in;
	end
	// Stall takes one cycle to show, like a registered downstream enable.
	always @(posedge clk_in)
	begin
		if (take)
			got.push_back(held);
		read_en_out <= #1 !stall_in;
	end
endmodule : fce_reader

// [verif/fce_cascade_tb.sv]
// Self-checking bench for the cascaded fall-through FIFO chain.
`timescale 1ns/100ps
module fce_cascade_tb;
	import fce_pkg::*;
	localparam int N = 2;
	localparam int D = 4;
	logic                        clk_in = 1'b0;
	logic                        reset_n_in = 1'b0;
	fce_xfer_t                   write_in = '0;
	logic                        stall = 1'b1;
	logic                        input_ready_n_out;
	logic                        read_en_in;
	logic                        output_ready_n_out;
	fce_word_t                   read_data_out;
	logic [$clog2(N*D+1)-1:0]    fill_level_out;
	fce_word_t                   sent[$];
	int                          bad_count = 0;
	int                          n_tests = 0;
	int                          cyc = 0;
	always #4 clk_in = ~clk_in;
	fce_cascade #(.N_STAGES(N), .STAGE_DEPTH(D)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.write_in(write_in), .input_ready_n_out(input_ready_n_out), .read_en_in(read_en_in),
		.read_data_out(read_data_out), .output_ready_n_out(output_ready_n_out), .fill_level_out(fill_level_out));
	fce_reader rd (.clk_in(clk_in), .stall_in(stall), .output_ready_n_in(output_ready_n_out),
		.read_data_in(read_data_out), .read_en_out(read_en_in));
	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// Valid stays up between calls so back-to-back writes never toggle it twice in a step.
	task automatic put(input int i, output logic acc);
		write_in.valid = 1'b1;
		write_in.data = {18'(i + 18'h00100), 18'(i)};
		@(negedge clk_in) acc = (input_ready_n_out === 1'b0);
		@(posedge clk_in) #1;
		if (acc)
			sent.push_back(write_in.data);
	endtask : put
	task automatic wait_low(ref logic flag, output int n);
		n = 0;
		while (flag !== 1'b0 && n < 50)
		begin
			@(posedge clk_in) #1;
			n++;
		end
	endtask : wait_low
	task automatic drain();
		int k;
		stall = 1'b0;
		for (k = 0; k < 60 && rd.got.size() < sent.size(); k++)
			@(posedge clk_in) #1;
		stall = 1'b1;
		check("count", 36'(rd.got.size()), 36'(sent.size()));
		foreach (sent[j])
			if (j < rd.got.size())
				check("word", rd.got[j], sent[j]);
		sent.delete();
		rd.got.delete();
		repeat (3) @(posedge clk_in) #1;
	endtask : drain
	task automatic t_ripple();
		logic acc;
		int n;
		put(1, acc);
		write_in.valid = 1'b0;
		wait_low(output_ready_n_out, n);
		check("ripple", 36'(n), 36'((N - 1) * 4 + 3));
		put(2, acc);
		put(3, acc);
		write_in.valid = 1'b0;
		check("head", read_data_out, sent[0]);
		drain();
	endtask : t_ripple
	task automatic t_full();
		logic acc;
		int n;
		for (n = 0; sent.size() < N * D && n < 60; n++)
			put(n + 16, acc);
		repeat (10) @(posedge clk_in) #1;
		put(99, acc);
		write_in.valid = 1'b0;
		check("refused", 36'(acc), 36'(0));
		check("level", 36'(fill_level_out), 36'(N * D));
		stall = 1'b0;
		@(posedge clk_in) #1;
		stall = 1'b1;
		@(posedge clk_in) #1;
		wait_low(input_ready_n_out, n);
		check("bubble", 36'(n), 36'((N - 1) * 3 + 2));
		drain();
	endtask : t_full
	// Main sequence: reset, then the scenarios in turn.
	initial
	begin
		repeat (12) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		repeat (3) @(posedge clk_in) #1;
		t_ripple();
		t_full();
		end_of_test();
	end
	// Hang guard well past the roughly ninety cycles the scenarios need.
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			end_of_test();
		end
	end
endmodule : fce_cascade_tb
